// ===== inc/lpfh_pkg.sv
// Package of constants and types for the line printer function handler.
package lpfh_pkg;
    localparam int WORD_W = 30;
    localparam int CHAR_W = 6;
    localparam int OP_HI = 29;
    localparam int OP_LO = 24;
    localparam int SP_HI = 23;
    localparam int SP_LO = 18;
    localparam int CHARS_PER_WORD = 5;
    localparam logic [2:0] LAST_CHAR = 3'h4;
    localparam logic [4:0] WORDS_PER_LINE = 5'h1b;
    localparam logic [CHAR_W-1:0] STOP_CHAR = 6'h3f;
    localparam logic [CHAR_W-1:0] CHAR_ZERO = 6'h00;

    // Function codes.
    localparam logic [5:0] OP_PRINT_INT = 6'h0a;
    localparam logic [5:0] OP_PRINT_NOINT = 6'h02;
    localparam logic [5:0] OP_TERM_INT = 6'h1b;
    localparam logic [5:0] OP_TERM_NOINT = 6'h13;

    // Status codes.
    localparam logic [5:0] ST_NORMAL = 6'h20;
    localparam logic [5:0] ST_OUT_OF_FORMS = 6'h24;
    localparam logic [5:0] ST_INVALID = 6'h28;
    localparam logic [5:0] ST_INTERLOCK = 6'h3c;
    localparam logic [23:0] STATUS_PAD = 24'h000000;

    // Timing at the 250 MHz control clock.
    localparam int CLK_MHZ = 250;
    localparam int WINDOW_NS = 6500;
    localparam int WINDOW_CYC = (WINDOW_NS * CLK_MHZ) / 1000;
    localparam int WIN_W = 11;
    localparam logic [WIN_W-1:0] WINDOW_LAST = WIN_W'(WINDOW_CYC - 1);

    // Bit positions in the synchronised pin vector.
    localparam int PIN_MC = 0;
    localparam int PIN_FS = 1;
    localparam int PIN_DACK = 2;
    localparam int PIN_SACK = 3;
    localparam int PIN_SPDONE = 4;
    localparam int PIN_PRDONE = 5;
    localparam int PIN_ILOCK = 6;
    localparam int PIN_OOF = 7;
    localparam int PIN_STOPSW = 8;
    localparam int PIN_DATA = 9;
    localparam int PIN_W = PIN_DATA + WORD_W;

    typedef enum logic [2:0] {
        S_IDLE, S_WINDOW, S_LOAD, S_PRINT, S_STATUS, S_HALT
    } lpfh_state_t;
endpackage

// ===== logic/lpfh_skid.sv
// Two-entry character buffer between the word splitter and the print buffer memory.
`timescale 1ns/100ps
module lpfh_skid (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    input wire logic in_valid_i,
    input wire logic [lpfh_pkg::CHAR_W-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [lpfh_pkg::CHAR_W-1:0] out_data_o,
    input wire logic out_ready_i
);
    import lpfh_pkg::*;

    typedef struct packed {
        logic out_valid;
        logic [CHAR_W-1:0] out_data;
        logic spare_valid;
        logic [CHAR_W-1:0] spare_data;
    } lpfh_skid_t;

    lpfh_skid_t q_r;
    lpfh_skid_t q_nxt;
    logic push;

    always_comb begin
        q_nxt = q_r;
        push = in_valid_i && !q_r.spare_valid;
        if (!q_r.out_valid || out_ready_i) begin
            if (q_r.spare_valid) begin
                q_nxt.out_data = q_r.spare_data;
                q_nxt.spare_valid = 1'b0;
            end else begin
                q_nxt.out_data = in_data_i;
                q_nxt.out_valid = push;
            end
        end else if (push) begin
            q_nxt.spare_data = in_data_i;
            q_nxt.spare_valid = 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            q_r <= '0;
        end else if (clk_en_i) begin
            q_r <= q_nxt;
        end
    end

    assign in_ready_o = !q_r.spare_valid;
    assign out_valid_o = q_r.out_valid;
    assign out_data_o = q_r.out_data;
endmodule

// ===== logic/lpfh_top.sv
// Function handler and line sequencer of the line printer control unit.
`timescale 1ns/100ps
module lpfh_top (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    input wire logic master_clear_line_i,
    input wire logic function_strobe_i,
    input wire logic data_word_ack_i,
    input wire logic status_accept_ack_i,
    input wire logic [lpfh_pkg::WORD_W-1:0] out_data_i,
    input wire logic stop_code_mode_i,
    input wire logic space_done_i,
    input wire logic print_done_i,
    input wire logic interlock_fault_i,
    input wire logic out_of_forms_i,
    input wire logic char_ready_i,
    output logic output_request_o,
    output logic status_interrupt_o,
    output logic [lpfh_pkg::WORD_W-1:0] in_data_o,
    output logic space_start_o,
    output logic [5:0] space_count_o,
    output logic print_start_o,
    output logic char_valid_o,
    output logic [lpfh_pkg::CHAR_W-1:0] char_data_o
);
    import lpfh_pkg::*;

    typedef struct packed {
        lpfh_state_t st;
        logic ord;
        logic irq;
        logic [WORD_W-1:0] in_data;
        logic sp_start;
        logic [5:0] sp_cnt;
        logic pr_start;
        logic pwi;
        logic term_int;
        logic term_noint;
        logic got_data;
        logic line_full;
        logic space_ok;
        logic space_armed;
        logic oof;
        logic [WORD_W-1:0] word;
        logic split;
        logic [2:0] cidx;
        logic [4:0] wcnt;
        logic [WIN_W-1:0] win;
        logic [5:0] code;
        logic [PIN_W-1:0] sync1;
        logic [PIN_W-1:0] sync2;
        logic [PIN_W-1:0] prev;
    } lpfh_core_t;

    lpfh_core_t q_r;
    lpfh_core_t q_nxt;
    logic buf_ready;
    logic [PIN_W-1:0] pins;
    logic [WORD_W-1:0] dw;
    logic [5:0] op;
    logic fs;
    logic dack;
    logic sack;
    logic sp_done;
    logic pr_done;
    logic ilock;
    logic busy;

    function automatic logic has_stop(input logic [WORD_W-1:0] w);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < CHARS_PER_WORD; i++) begin
            if (w[i*CHAR_W +: CHAR_W] == STOP_CHAR) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    // Builds a status word; the two low code bits are forced to zero.
    function automatic logic [WORD_W-1:0] status_word(input logic [5:0] c);
        return {c[5:2], 2'b00, STATUS_PAD};
    endfunction

    assign pins = {out_data_i, stop_code_mode_i, out_of_forms_i, interlock_fault_i,
                   print_done_i, space_done_i, status_accept_ack_i, data_word_ack_i,
                   function_strobe_i, master_clear_line_i};
    assign dw = q_r.sync2[PIN_DATA +: WORD_W];
    assign op = dw[OP_HI:OP_LO];
    assign fs = q_r.sync2[PIN_FS] && !q_r.prev[PIN_FS];
    assign dack = q_r.sync2[PIN_DACK] && !q_r.prev[PIN_DACK];
    assign sack = q_r.sync2[PIN_SACK] && !q_r.prev[PIN_SACK];
    assign sp_done = q_r.sync2[PIN_SPDONE] && !q_r.prev[PIN_SPDONE];
    assign pr_done = q_r.sync2[PIN_PRDONE] && !q_r.prev[PIN_PRDONE];
    assign ilock = q_r.sync2[PIN_ILOCK];
    assign busy = q_r.st == S_WINDOW || q_r.st == S_LOAD || q_r.st == S_PRINT;

    always_comb begin
        q_nxt = q_r;
        q_nxt.sync1 = pins;
        q_nxt.sync2 = q_r.sync1;
        q_nxt.prev = q_r.sync2;
        q_nxt.sp_start = 1'b0;
        q_nxt.pr_start = 1'b0;
        // Characters leave most significant first.
        if (q_r.split && buf_ready) begin
            q_nxt.word = {q_r.word[WORD_W-CHAR_W-1:0], CHAR_ZERO};
            q_nxt.cidx = q_r.cidx + 3'h1;
            if (q_r.cidx == LAST_CHAR) begin
                q_nxt.split = 1'b0;
            end
        end
        if (sp_done && q_r.space_armed) begin
            q_nxt.space_ok = 1'b1;
        end
        if (q_r.sync2[PIN_OOF] && !q_r.prev[PIN_OOF] && q_r.space_armed) begin
            q_nxt.oof = 1'b1;
        end
        if (dack && q_r.ord && (q_r.st == S_WINDOW || q_r.st == S_LOAD)) begin
            q_nxt.word = dw;
            q_nxt.split = 1'b1;
            q_nxt.cidx = 3'h0;
            q_nxt.got_data = 1'b1;
            q_nxt.wcnt = q_r.wcnt + 5'h1;
            if (q_nxt.wcnt == WORDS_PER_LINE) begin
                q_nxt.line_full = 1'b1;
            end
            if (q_r.sync2[PIN_STOPSW] && has_stop(dw)) begin
                q_nxt.line_full = 1'b1;
            end
            // Later lines start spacing on their first word.
            if (q_r.st == S_LOAD && !q_r.space_armed) begin
                q_nxt.space_armed = 1'b1;
                q_nxt.sp_start = 1'b1;
            end
        end
        case (q_r.st)
            S_IDLE: begin
                if (fs && (op == OP_PRINT_INT || op == OP_PRINT_NOINT)) begin
                    q_nxt.st = S_WINDOW;
                    q_nxt.pwi = op == OP_PRINT_INT;
                    q_nxt.sp_cnt = dw[SP_HI:SP_LO];
                    q_nxt.win = '0;
                    q_nxt.got_data = 1'b0;
                    q_nxt.line_full = 1'b0;
                    q_nxt.wcnt = '0;
                    q_nxt.space_ok = 1'b0;
                    q_nxt.space_armed = 1'b0;
                    q_nxt.term_int = 1'b0;
                    q_nxt.term_noint = 1'b0;
                    q_nxt.oof = 1'b0;
                end else if (fs && op == OP_TERM_INT) begin
                    q_nxt.st = S_STATUS;
                    q_nxt.code = ST_NORMAL;
                end else if (fs && op != OP_TERM_NOINT) begin
                    q_nxt.st = S_STATUS;
                    q_nxt.code = ST_INVALID;
                end
            end
            S_WINDOW, S_LOAD: begin
                if (q_r.st == S_WINDOW) begin
                    q_nxt.win = q_r.win + 1'b1;
                    if (q_r.win == WINDOW_LAST) begin
                        q_nxt.st = S_LOAD;
                        q_nxt.sp_start = 1'b1;
                        q_nxt.space_armed = 1'b1;
                    end
                end
                if (fs && (op == OP_TERM_INT || op == OP_TERM_NOINT)) begin
                    if (q_r.st == S_WINDOW && !q_r.got_data) begin
                        // Early terminate: spacing never starts.
                        q_nxt.sp_start = 1'b0;
                        q_nxt.space_armed = 1'b0;
                        if (op == OP_TERM_INT) begin
                            q_nxt.st = S_STATUS;
                            q_nxt.code = ilock ? ST_INTERLOCK : ST_NORMAL;
                        end else begin
                            q_nxt.st = S_IDLE;
                        end
                    end else begin
                        q_nxt.term_int = op == OP_TERM_INT;
                        q_nxt.term_noint = op == OP_TERM_NOINT;
                        q_nxt.line_full = q_r.got_data;
                    end
                end else if (fs) begin
                    q_nxt.st = S_STATUS;
                    q_nxt.code = ST_INVALID;
                end else if (q_r.st == S_LOAD && (q_r.space_ok || !q_r.space_armed)) begin
                    if (q_r.line_full && !q_r.split) begin
                        q_nxt.st = S_PRINT;
                        q_nxt.pr_start = 1'b1;
                    end else if (!q_r.got_data && q_r.term_int) begin
                        q_nxt.st = S_STATUS;
                        q_nxt.code = q_r.oof ? ST_OUT_OF_FORMS : ST_NORMAL;
                    end else if (!q_r.got_data && q_r.term_noint) begin
                        q_nxt.st = q_r.oof ? S_STATUS : S_IDLE;
                        q_nxt.code = ST_OUT_OF_FORMS;
                    end
                end
            end
            S_PRINT: begin
                if (fs && (op == OP_TERM_INT || op == OP_TERM_NOINT)) begin
                    q_nxt.term_int = op == OP_TERM_INT;
                    q_nxt.term_noint = op == OP_TERM_NOINT;
                end else if (pr_done) begin
                    if (q_r.oof) begin
                        q_nxt.st = S_STATUS;
                        q_nxt.code = ST_OUT_OF_FORMS;
                    end else if (q_r.pwi || q_r.term_int) begin
                        q_nxt.st = S_STATUS;
                        q_nxt.code = ST_NORMAL;
                    end else if (q_r.term_noint) begin
                        q_nxt.st = S_IDLE;
                    end else begin
                        q_nxt.st = S_LOAD;
                        q_nxt.got_data = 1'b0;
                        q_nxt.line_full = 1'b0;
                        q_nxt.wcnt = '0;
                        q_nxt.space_ok = 1'b0;
                        q_nxt.space_armed = 1'b0;
                    end
                end
            end
            S_STATUS: begin
                if (sack) begin
                    q_nxt.st = q_r.code == ST_NORMAL ? S_IDLE : S_HALT;
                end else if (fs && op == OP_TERM_NOINT) begin
                    // A pending fault is shown again; completion is dropped.
                    q_nxt.st = q_r.code == ST_NORMAL ? S_IDLE : S_STATUS;
                end
            end
            S_HALT: begin
                if (fs && op == OP_TERM_INT) begin
                    q_nxt.st = S_STATUS;
                    q_nxt.code = ST_NORMAL;
                end else if (fs && op == OP_TERM_NOINT) begin
                    q_nxt.st = S_IDLE;
                end else if (fs) begin
                    q_nxt.st = S_STATUS;
                    q_nxt.code = ST_INVALID;
                end
            end
            default: begin
                q_nxt.st = S_IDLE;
            end
        endcase
        if (busy && ilock) begin
            q_nxt.st = S_STATUS;
            q_nxt.code = ST_INTERLOCK;
        end
        q_nxt.irq = q_nxt.st == S_STATUS;
        q_nxt.in_data = q_nxt.irq ? status_word(q_nxt.code) : '0;
        if (q_nxt.st == S_IDLE) begin
            q_nxt.ord = 1'b1;
        end else if (q_nxt.st == S_WINDOW || q_nxt.st == S_LOAD) begin
            q_nxt.ord = !q_nxt.line_full && !q_nxt.split && !q_nxt.term_int &&
                        !q_nxt.term_noint && !(dack && q_r.ord);
        end else begin
            q_nxt.ord = 1'b0;
        end
        if (q_r.sync2[PIN_MC]) begin
            q_nxt = '0;
            q_nxt.sync1 = pins;
            q_nxt.sync2 = q_r.sync1;
            q_nxt.prev = q_r.sync2;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            q_r <= '0;
        end else if (clk_en_i) begin
            q_r <= q_nxt;
        end
    end

    lpfh_skid u_skid (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .clk_en_i(clk_en_i),
        .in_valid_i(q_r.split),
        .in_data_i(q_r.word[OP_HI:OP_LO]),
        .in_ready_o(buf_ready),
        .out_valid_o(char_valid_o),
        .out_data_o(char_data_o),
        .out_ready_i(char_ready_i)
    );

    assign output_request_o = q_r.ord;
    assign status_interrupt_o = q_r.irq;
    assign in_data_o = q_r.in_data;
    assign space_start_o = q_r.sp_start;
    assign space_count_o = q_r.sp_cnt;
    assign print_start_o = q_r.pr_start;

    default clocking cb @(posedge clock_i iff clk_en_i); endclocking
    default disable iff (!rst_b_i);

    sequence early_term_int;
        q_r.st == S_WINDOW && fs && op == OP_TERM_INT && !q_r.got_data && !ilock &&
        !q_r.sync2[PIN_MC];
    endsequence
    sequence normal_report;
        status_interrupt_o && in_data_o == status_word(ST_NORMAL);
    endsequence

    AST_STATUS_FORMAT: assert property (status_interrupt_o |-> in_data_o[25:0] == '0)
        else $error("Status word carries nonzero low bits.");
    AST_NO_REQUEST_WITH_IRQ: assert property (status_interrupt_o |-> !output_request_o)
        else $error("Output request raised while status pending.");
    AST_EARLY_TERM_IRQ: assert property (early_term_int |=> normal_report)
        else $error("Early terminate did not report completion at once.");
    AST_EARLY_TERM_NO_SPACE: assert property (early_term_int |=> (!space_start_o)[*4])
        else $error("Paper spacing started after early terminate.");
    AST_PRINT_GATED: assert property ($rose(print_start_o) |->
            $past(q_r.space_ok) && $past(q_r.line_full))
        else $error("Print started before spacing and loading ended.");
    AST_LINE_FULL_27: assert property (q_r.wcnt == WORDS_PER_LINE |-> q_r.line_full)
        else $error("Line not complete after the last word.");
    AST_MASTER_CLEAR: assert property (q_r.sync2[PIN_MC] |=> q_r.st == S_IDLE)
        else $error("Master clear did not return to idle.");
    AST_PWI_DONE: assert property (q_r.st == S_PRINT && pr_done && q_r.pwi && !q_r.oof &&
            !ilock && !q_r.sync2[PIN_MC] && !(fs && (op == OP_TERM_INT || op == OP_TERM_NOINT))
            |=> normal_report)
        else $error("Completed line gave no normal status.");
    AST_INTERLOCK_NOW: assert property (busy && ilock && !q_r.sync2[PIN_MC] |=>
            status_interrupt_o && in_data_o == status_word(ST_INTERLOCK))
        else $error("Interlock fault not reported at once.");
endmodule

// ===== testbench/lpfh_host_model.sv
// Host channel model that sends function words, data words and status acknowledges.
`timescale 1ns/100ps
module lpfh_host_model
    import lpfh_pkg::*;
(
    input wire logic clock_i,
    input wire logic output_request_i,
    output logic function_strobe_o,
    output logic data_word_ack_o,
    output logic status_accept_ack_o,
    output logic [lpfh_pkg::WORD_W-1:0] out_data_o
);
    int stalls = 0;

    initial begin
        function_strobe_o = 1'b0;
        data_word_ack_o = 1'b0;
        status_accept_ack_o = 1'b0;
        out_data_o = 30'h0;
    end

    task automatic drive(input int which, input logic lvl);
        case (which)
            0: function_strobe_o <= lvl;
            1: data_word_ack_o <= lvl;
            default: status_accept_ack_o <= lvl;
        endcase
    endtask

    // Each pin is held four cycles high and low so the synchronisers see both levels.
    task automatic pulse(input int which, input logic [WORD_W-1:0] val);
        @(posedge clock_i);
        out_data_o <= val;
        drive(which, 1'b1);
        repeat (4) @(posedge clock_i);
        drive(which, 1'b0);
        repeat (4) @(posedge clock_i);
        out_data_o <= ~val;
    endtask

    task automatic send_word(input logic [WORD_W-1:0] val);
        int n;
        n = 0;
        while (output_request_i !== 1'b1 && n < 8000) begin
            @(posedge clock_i);
            n++;
        end
        if (n == 8000) stalls++;
        pulse(1, val);
    endtask
endmodule

// ===== testbench/lpfh_top_tb.sv
// Self-checking testbench of the line printer function handler.
`timescale 1ns/100ps
module lpfh_top_tb;
    import lpfh_pkg::*;
    logic clock_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic mc = 1'b0;
    logic stop_mode = 1'b0;
    logic space_done = 1'b0;
    logic print_done = 1'b0;
    logic ilock = 1'b0;
    logic oof = 1'b0;
    logic char_ready = 1'b0;
    logic fs, dack, sack, req, intr, sp_start, pr_start, cvalid;
    logic [WORD_W-1:0] odata, idata;
    logic [5:0] sp_count;
    logic [CHAR_W-1:0] cdata;
    logic [CHAR_W-1:0] exp_q[$];
    logic ok, chk_on = 1'b0, sp_busy = 1'b0;
    int fails = 0, checked = 0, cyc = 0, n_space = 0, n_print = 0, b_sp, b_pr;
    localparam logic [WORD_W-1:0] ST_OK = {ST_NORMAL, STATUS_PAD};

    lpfh_top uut (.clock_i(clock_i), .rst_b_i(rst_b_i), .clk_en_i(1'b1),
        .master_clear_line_i(mc), .function_strobe_i(fs), .data_word_ack_i(dack),
        .status_accept_ack_i(sack), .out_data_i(odata), .stop_code_mode_i(stop_mode),
        .space_done_i(space_done), .print_done_i(print_done), .interlock_fault_i(ilock),
        .out_of_forms_i(oof), .char_ready_i(char_ready), .output_request_o(req),
        .status_interrupt_o(intr), .in_data_o(idata), .space_start_o(sp_start),
        .space_count_o(sp_count), .print_start_o(pr_start), .char_valid_o(cvalid),
        .char_data_o(cdata));
    lpfh_host_model host (.clock_i(clock_i), .output_request_i(req),
        .function_strobe_o(fs), .data_word_ack_o(dack), .status_accept_ack_o(sack),
        .out_data_o(odata));

    initial forever #2 clock_i = ~clock_i;

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wait_sig(input int which, input int lim, output logic hit);
        int n;
        n = 0;
        hit = 1'b0;
        while (!hit && n < lim) begin
            @(posedge clock_i);
            n++;
            case (which)
                0: hit = (req === 1'b1);
                1: hit = (intr === 1'b1);
                default: hit = (intr === 1'b0);
            endcase
        end
    endtask

    // Bits 17..0 carry noise that the unit must ignore.
    task automatic fn(input logic [5:0] op, input logic [5:0] sp);
        host.pulse(0, {op, sp, 18'h2aaaa});
    endtask

    task automatic word(input logic [WORD_W-1:0] w);
        if (chk_on)
            for (int k = 0; k < CHARS_PER_WORD; k++) exp_q.push_back(w[29-6*k -: 6]);
        host.send_word(w);
    endtask

    task automatic ack_status();
        host.pulse(2, 30'h0);
        wait_sig(0, 50, ok);
    endtask

    // Printer mechanism: answers each spacing and print order after a short delay.
    initial forever begin
        @(posedge clock_i);
        if (sp_start === 1'b1) begin
            n_space++;
            sp_busy = 1'b1;
            repeat (30) @(posedge clock_i);
            space_done <= 1'b1;
            sp_busy = 1'b0;
            repeat (4) @(posedge clock_i);
            space_done <= 1'b0;
        end else if (pr_start === 1'b1) begin
            n_print++;
            repeat (30) @(posedge clock_i);
            print_done <= 1'b1;
            repeat (4) @(posedge clock_i);
            print_done <= 1'b0;
        end
    end

    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        char_ready <= (cyc % 16) < 12;
        if (pr_start === 1'b1) chk(30'(sp_busy), 30'h0);
        if (chk_on && cvalid === 1'b1 && char_ready)
            chk(30'(cdata), 30'(exp_q.pop_front()));
        if (cyc == 60000) begin
            fails++;
            report_and_stop();
        end
    end

    task automatic t_invalid();
        chk(30'(req), 30'h1);
        fn(6'h3e, 6'h00);
        wait_sig(1, 50, ok);
        chk(idata, {ST_INVALID, STATUS_PAD});
        host.pulse(2, 30'h0);
        fn(OP_TERM_NOINT, 6'h00);
        wait_sig(0, 50, ok);
        chk(30'(ok), 30'h1);
        $display("test invalid done");
    endtask

    task automatic t_full_line();
        b_sp = n_space;
        b_pr = n_print;
        chk_on = 1'b1;
        fn(OP_PRINT_INT, 6'h05);
        for (int i = 0; i < 27; i++) word({6'(i), 6'h01, 6'h02, 6'h03, 6'h04});
        repeat (20) @(posedge clock_i);
        chk(30'(req), 30'h0);
        chk(30'(sp_count), 30'h5);
        wait_sig(1, 4000, ok);
        chk(idata, ST_OK);
        chk(30'(n_space - b_sp), 30'h1);
        chk(30'(n_print - b_pr), 30'h1);
        chk(30'(exp_q.size()), 30'h0);
        ack_status();
        chk(30'(ok), 30'h1);
        $display("test full line done");
    endtask

    task automatic t_stop_and_term();
        b_pr = n_print;
        chk_on = 1'b0;
        stop_mode <= 1'b1;
        fn(OP_PRINT_INT, 6'h00);
        word({6'h11, STOP_CHAR, 18'h00000});
        repeat (20) @(posedge clock_i);
        chk(30'(req), 30'h0);
        wait_sig(1, 4000, ok);
        chk(idata, ST_OK);
        chk(30'(n_print - b_pr), 30'h1);
        ack_status();
        stop_mode <= 1'b0;
        chk_on = 1'b1;
        fn(OP_PRINT_INT, 6'h01);
        word(30'h01234567);
        word(30'h12345678);
        fn(OP_TERM_INT, 6'h00);
        wait_sig(1, 4000, ok);
        chk(30'(n_print - b_pr), 30'h2);
        chk(idata, ST_OK);
        ack_status();
        $display("test stop and terminate done");
    endtask

    task automatic t_early_terms();
        b_sp = n_space;
        fn(OP_PRINT_INT, 6'h03);
        fn(OP_TERM_INT, 6'h00);
        wait_sig(1, 125, ok);
        chk(30'(ok), 30'h1);
        chk(idata, ST_OK);
        ack_status();
        fn(OP_PRINT_NOINT, 6'h02);
        fn(OP_TERM_NOINT, 6'h00);
        wait_sig(0, 450, ok);
        chk(30'(ok), 30'h1);
        repeat (2000) @(posedge clock_i);
        chk(30'(n_space - b_sp), 30'h0);
        chk(30'(intr), 30'h0);
        $display("test early terminates done");
    endtask

    task automatic t_repeat_fault();
        b_sp = n_space;
        fn(OP_PRINT_NOINT, 6'h02);
        for (int i = 0; i < 27; i++) word({6'h05, 6'(i), 18'h0a28a});
        repeat (20) @(posedge clock_i);
        chk(30'(req), 30'h0);
        wait_sig(0, 4000, ok);
        chk(30'(ok), 30'h1);
        chk(30'(intr), 30'h0);
        chk(30'(exp_q.size()), 30'h0);
        chk_on = 1'b0;
        word(30'h02082082);
        repeat (10) @(posedge clock_i);
        chk(30'(n_space - b_sp), 30'h2);
        chk(30'(sp_count), 30'h2);
        ilock <= 1'b1;
        wait_sig(1, 50, ok);
        chk(idata, {ST_INTERLOCK, STATUS_PAD});
        fn(OP_TERM_NOINT, 6'h00);
        chk(30'(intr), 30'h1);
        chk(30'(req), 30'h0);
        host.pulse(2, 30'h0);
        ilock <= 1'b0;
        wait_sig(2, 50, ok);
        chk(30'(req), 30'h0);
        fn(OP_TERM_NOINT, 6'h00);
        wait_sig(0, 4000, ok);
        chk(30'(ok), 30'h1);
        $display("test repeated print and fault done");
    endtask

    task automatic t_master_clear();
        fn(OP_PRINT_INT, 6'h00);
        word(30'h0410c410);
        mc <= 1'b1;
        repeat (5) @(posedge clock_i);
        mc <= 1'b0;
        wait_sig(0, 20, ok);
        chk(30'(ok), 30'h1);
        chk(30'(intr), 30'h0);
        chk(30'(host.stalls), 30'h0);
        $display("test master clear done");
    endtask

    // Ends an unattended print with no data pending, then an out-of-forms late terminate.
    task automatic t_forms_and_end();
        b_pr = n_print;
        stop_mode <= 1'b1;
        fn(OP_PRINT_NOINT, 6'h01);
        word({STOP_CHAR, 24'h000000});
        wait_sig(0, 4000, ok);
        chk(30'(n_print - b_pr), 30'h1);
        fn(OP_TERM_INT, 6'h00);
        wait_sig(1, 50, ok);
        chk(idata, ST_OK);
        ack_status();
        chk(30'(ok), 30'h1);
        stop_mode <= 1'b0;
        fn(OP_PRINT_INT, 6'h02);
        wait (sp_busy === 1'b1);
        @(posedge clock_i);
        oof <= 1'b1;
        fn(OP_TERM_INT, 6'h00);
        chk(30'(intr), 30'h0);
        wait_sig(1, 100, ok);
        chk(idata, {ST_OUT_OF_FORMS, STATUS_PAD});
        fn(OP_TERM_NOINT, 6'h00);
        chk(idata, {ST_OUT_OF_FORMS, STATUS_PAD});
        host.pulse(2, 30'h0);
        oof <= 1'b0;
        chk(30'(req), 30'h0);
        fn(OP_TERM_NOINT, 6'h00);
        wait_sig(0, 50, ok);
        chk(30'(ok), 30'h1);
        $display("test forms and end done");
    endtask

    initial begin
        repeat (20) @(posedge clock_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        t_invalid();
        t_full_line();
        t_stop_and_term();
        t_early_terms();
        t_repeat_fault();
        t_master_clear();
        t_forms_and_end();
        report_and_stop();
    end
endmodule
